// file: card_cmd_parser.sv
// Shared constants for the card command interpreter, and the command frame parser.
// Assumes command bytes arrive from CLA onward, one per accepted strobe, last byte flagged.
package card_cmd_pkg;
    localparam int K_W = 9;
    localparam logic [7:0] CLA_OK = 8'h90;
    localparam logic [3:0] CLA_HI_OK = 4'h9;
    localparam logic [3:0] CLA_LO_OK = 4'h0;
    localparam logic [7:0] INS_SESSION_END = 8'h76;
    localparam logic [7:0] INS_POWER_ON = 8'h80;
    localparam logic [7:0] INS_BALANCE = 8'h44;
    localparam logic [7:0] P_ZERO = 8'h00;
    localparam logic [7:0] LE_ZERO = 8'h00;
    localparam logic [7:0] LC_SESSION_END = 8'h02;
    localparam logic [7:0] LC_POWER_ON = 8'h01;
    localparam logic [3:0] LEN_SESSION_END = 4'h8;
    localparam logic [3:0] LEN_POWER_ON = 4'h7;
    localparam logic [3:0] LEN_BALANCE = 4'h5;
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_LENGTH = 16'h6700;
    localparam logic [15:0] SW_CLA_LO = 16'h6800;
    localparam logic [15:0] SW_P1P2 = 16'h6A86;
    localparam logic [15:0] SW_INS = 16'h6D00;
    localparam logic [15:0] SW_CLA_HI = 16'h6E00;
    localparam logic [7:0] PROTO_UNIT = 8'h00;
    localparam logic [7:0] FIRST_PDU = 8'h00;
    // Response byte positions, counted from the protocol unit number at offset +3
    localparam logic [K_W-1:0] K_PROTO = 9'h000;
    localparam logic [K_W-1:0] K_ULEN = 9'h001;
    localparam logic [K_W-1:0] K_INSTR_HI = 9'h002;
    localparam logic [K_W-1:0] K_INSTR_LO = 9'h003;
    localparam logic [K_W-1:0] K_RET_HI = 9'h004;
    localparam logic [K_W-1:0] K_RET_LO = 9'h005;
    localparam logic [K_W-1:0] K_FIELD0 = 9'h006;
    localparam logic [K_W-1:0] K_FIELD1 = 9'h007;
    localparam logic [K_W-1:0] K_PON_REC = 9'h008;
    localparam logic [K_W-1:0] K_UPLOAD = 9'h008;
    localparam logic [K_W-1:0] K_END_SW2_BASE = 9'h009;
    localparam logic [K_W-1:0] K_PON_SW2 = 9'h013;
    localparam logic [K_W-1:0] K_BAL_SW2_BASE = 9'h009;
    localparam logic [K_W-1:0] K_ERR_SW2 = 9'h001;
    localparam logic [7:0] ULEN_FIXED = 8'h06;
    localparam logic [7:0] ULEN_POWER_ON = 8'h10;
    localparam int REC_BYTES = 10;
    localparam int STR_MAX = 21;
    typedef enum logic [1:0] {CMD_SESSION_END, CMD_POWER_ON, CMD_BALANCE} cmd_e;
endpackage

`timescale 1ns/1ps
module card_cmd_parser (
    input wire logic clk,
    input wire logic rst,
    input wire logic take,
    input wire logic [7:0] byte_in,
    input wire logic last_in,
    output logic done,
    output logic [7:0] ins,
    output logic [7:0] index,
    output logic [15:0] status
);
    logic [3:0] pos;
    logic [7:0] cla;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;

    // ************************************************
    // Status checks, in the card's order of precedence
    // ************************************************
    function automatic logic [15:0] frame_status(input logic [7:0] c, input logic [7:0] i,
            input logic [7:0] a, input logic [7:0] b, input logic [7:0] l,
            input logic [3:0] n, input logic [7:0] le);
        logic [15:0] s;
        s = card_cmd_pkg::SW_OK;
        if (c[7:4] != card_cmd_pkg::CLA_HI_OK) begin
            s = card_cmd_pkg::SW_CLA_HI;
        end else if (c[3:0] != card_cmd_pkg::CLA_LO_OK) begin
            s = card_cmd_pkg::SW_CLA_LO;
        end else if (i != card_cmd_pkg::INS_SESSION_END && i != card_cmd_pkg::INS_POWER_ON &&
                i != card_cmd_pkg::INS_BALANCE) begin
            s = card_cmd_pkg::SW_INS;
        end else if (a != card_cmd_pkg::P_ZERO || b != card_cmd_pkg::P_ZERO) begin
            s = card_cmd_pkg::SW_P1P2;
        end else if (le != card_cmd_pkg::LE_ZERO) begin
            s = card_cmd_pkg::SW_LENGTH;
        end else if (i == card_cmd_pkg::INS_SESSION_END) begin
            if (n != card_cmd_pkg::LEN_SESSION_END || l != card_cmd_pkg::LC_SESSION_END) begin
                s = card_cmd_pkg::SW_LENGTH;
            end
        end else if (i == card_cmd_pkg::INS_POWER_ON) begin
            if (n != card_cmd_pkg::LEN_POWER_ON || l != card_cmd_pkg::LC_POWER_ON) begin
                s = card_cmd_pkg::SW_LENGTH;
            end
        end else if (n != card_cmd_pkg::LEN_BALANCE) begin
            s = card_cmd_pkg::SW_LENGTH;
        end
        return s;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= 4'h0;
        end else if (take) begin
            pos <= last_in ? 4'h0 : (pos == 4'hF ? pos : pos + 4'h1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cla <= 8'h00;
            ins <= 8'h00;
            p1 <= 8'h00;
            p2 <= 8'h00;
            lc <= 8'h00;
            index <= 8'h00;
        end else if (take) begin
            unique case (pos)
                4'h0: cla <= byte_in;
                4'h1: ins <= byte_in;
                4'h2: p1 <= byte_in;
                4'h3: p2 <= byte_in;
                4'h4: lc <= byte_in;
                4'h5: index <= byte_in;
                default: ;
            endcase
        end
    end

    // Short frames leave later fields stale; the length check rejects them anyway
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            status <= card_cmd_pkg::SW_OK;
        end else begin
            done <= take && last_in;
            if (take && last_in) begin
                status <= (pos < 4'h4) ? card_cmd_pkg::SW_LENGTH :
                    frame_status(cla, ins, p1, p2, lc, pos + 4'h1, byte_in);
            end
        end
    end

    a_done_pulse: assert property (@(posedge clk) disable iff (rst)
        done |=> !done) else $error("frame done held longer than one cycle");
endmodule

// file: card_cmd_interp.sv
// Card command interpreter: session end, power-on control information, prepaid balance.
// Assumes a byte-wide command stream from the host and a byte-wide response stream back;
// card data tables are loaded by the card's own firmware through the load ports.
// Function
// - Session-end answer: unit 00, length, instruction, return code, PDU 00, final PDU, data, SW.
// - Power-on answer echoes the index and gives final index n-1.
// - Power-on answer fields sit at offsets 11 to 20, status at 21 and 22.
// - Reference date is a modified_julian_date; offset and period count days.
// - Hold-time byte gives supply hold after the viewer switches off.
// - Network and stream fields identify the entitlement_message transport_stream.
// - Balance answer: group string at offset 9, up to 21 bytes, then balance.
// - An erroneous command answers with the two status bytes only.
`timescale 1ns/1ps
module card_cmd_interp #(
    parameter int INFO_DEPTH = 16,
    parameter int IDX_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_last,
    input wire logic rsp_ready,
    input wire logic [15:0] card_instruction,
    input wire logic [15:0] return_code,
    input wire logic prepaid_card,
    input wire logic [7:0] final_pdu,
    input wire logic [7:0] upload_len,
    input wire logic up_valid,
    input wire logic [7:0] up_byte,
    output logic up_ready,
    input wire logic info_wr_en,
    input wire logic [IDX_W-1:0] info_wr_idx,
    input wire logic [79:0] info_wr_rec,
    input wire logic [7:0] info_count,
    input wire logic str_wr_en,
    input wire logic [4:0] str_wr_addr,
    input wire logic [7:0] str_wr_byte,
    input wire logic [4:0] str_len,
    input wire logic [15:0] balance
);
    typedef enum logic {ST_IDLE, ST_SEND} state_e;
    localparam int KW = card_cmd_pkg::K_W;

    state_e state;
    card_cmd_pkg::cmd_e kind;
    logic err;
    logic [15:0] sw;
    logic [7:0] idx;
    logic [KW-1:0] k;
    logic [KW-1:0] k_out;
    logic [KW-1:0] last_k;
    logic [7:0] ulen;
    logic [7:0] next_byte;
    logic need_up;
    logic load;
    logic p_done;
    logic [7:0] p_ins;
    logic [7:0] p_index;
    logic [15:0] p_status;
    // Record: group, date(2), date offset, period, hold time, network(2), stream(2)
    logic [79:0] info_mem [INFO_DEPTH];
    logic [7:0] str_mem [card_cmd_pkg::STR_MAX];
    logic [79:0] rec;
    logic [KW-1:0] j;

    card_cmd_parser u_parser (
        .clk(clk),
        .rst(rst),
        .take(cmd_valid && cmd_ready),
        .byte_in(cmd_byte),
        .last_in(cmd_last),
        .done(p_done),
        .ins(p_ins),
        .index(p_index),
        .status(p_status)
    );

    // ************************************************
    // Card data tables
    // ************************************************
    always_ff @(posedge clk) begin
        if (info_wr_en) begin
            info_mem[info_wr_idx] <= info_wr_rec;
        end
        if (str_wr_en) begin
            str_mem[str_wr_addr] <= str_wr_byte;
        end
    end

    // ************************************************
    // Command acceptance
    // ************************************************
    // One command at a time: the host waits while an answer is pending
    assign cmd_ready = (state == ST_IDLE) && !p_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kind <= card_cmd_pkg::CMD_SESSION_END;
            err <= 1'b0;
            sw <= card_cmd_pkg::SW_OK;
            idx <= 8'h00;
        end else if (p_done) begin
            idx <= p_index;
            unique case (p_ins)
                card_cmd_pkg::INS_POWER_ON: kind <= card_cmd_pkg::CMD_POWER_ON;
                card_cmd_pkg::INS_BALANCE: kind <= card_cmd_pkg::CMD_BALANCE;
                default: kind <= card_cmd_pkg::CMD_SESSION_END;
            endcase
            if (p_status != card_cmd_pkg::SW_OK) begin
                err <= 1'b1;
                sw <= p_status;
            end else if (p_ins == card_cmd_pkg::INS_POWER_ON &&
                    (p_index >= info_count || p_index >= 8'(INFO_DEPTH))) begin
                err <= 1'b1;
                sw <= card_cmd_pkg::SW_P1P2;
            end else if (p_ins == card_cmd_pkg::INS_BALANCE && !prepaid_card) begin
                err <= 1'b1;
                sw <= card_cmd_pkg::SW_INS;
            end else begin
                err <= 1'b0;
                sw <= card_cmd_pkg::SW_OK;
            end
        end
    end

    // ************************************************
    // Response layout
    // ************************************************
    always_comb begin
        last_k = card_cmd_pkg::K_PON_SW2;
        ulen = card_cmd_pkg::ULEN_POWER_ON;
        if (err) begin
            last_k = card_cmd_pkg::K_ERR_SW2;
        end else if (kind == card_cmd_pkg::CMD_SESSION_END) begin
            last_k = card_cmd_pkg::K_END_SW2_BASE + KW'(upload_len);
            ulen = card_cmd_pkg::ULEN_FIXED + upload_len;
        end else if (kind == card_cmd_pkg::CMD_BALANCE) begin
            last_k = card_cmd_pkg::K_BAL_SW2_BASE + KW'(str_len);
            ulen = card_cmd_pkg::ULEN_FIXED + 8'(str_len);
        end
    end

    assign rec = info_mem[idx[IDX_W-1:0]];
    assign j = k - card_cmd_pkg::K_PON_REC;
    assign need_up = !err && kind == card_cmd_pkg::CMD_SESSION_END &&
        k >= card_cmd_pkg::K_UPLOAD && k < last_k - KW'(1);

    always_comb begin
        next_byte = 8'h00;
        if (k == last_k) begin
            next_byte = sw[7:0];
        end else if (k == last_k - KW'(1)) begin
            next_byte = sw[15:8];
        end else if (k == card_cmd_pkg::K_PROTO) begin
            next_byte = card_cmd_pkg::PROTO_UNIT;
        end else if (k == card_cmd_pkg::K_ULEN) begin
            next_byte = ulen;
        end else if (k == card_cmd_pkg::K_INSTR_HI) begin
            next_byte = card_instruction[15:8];
        end else if (k == card_cmd_pkg::K_INSTR_LO) begin
            next_byte = card_instruction[7:0];
        end else if (k == card_cmd_pkg::K_RET_HI) begin
            next_byte = return_code[15:8];
        end else if (k == card_cmd_pkg::K_RET_LO) begin
            next_byte = return_code[7:0];
        end else begin
            unique case (kind)
                card_cmd_pkg::CMD_SESSION_END: begin
                    if (k == card_cmd_pkg::K_FIELD0) begin
                        next_byte = card_cmd_pkg::FIRST_PDU;
                    end else if (k == card_cmd_pkg::K_FIELD1) begin
                        next_byte = final_pdu;
                    end else begin
                        next_byte = up_byte;
                    end
                end
                card_cmd_pkg::CMD_POWER_ON: begin
                    if (k == card_cmd_pkg::K_FIELD0) begin
                        next_byte = idx;
                    end else if (k == card_cmd_pkg::K_FIELD1) begin
                        next_byte = info_count - 8'h01;
                    end else begin
                        // Record walked from its top byte down
                        next_byte = rec[8'(79) - 8'(j) * 8'(8) -: 8];
                    end
                end
                default: begin
                    if (k < card_cmd_pkg::K_FIELD0 + KW'(str_len)) begin
                        next_byte = str_mem[5'(k - card_cmd_pkg::K_FIELD0)];
                    end else if (k == card_cmd_pkg::K_FIELD0 + KW'(str_len)) begin
                        next_byte = balance[15:8];
                    end else begin
                        next_byte = balance[7:0];
                    end
                end
            endcase
        end
    end

    // ************************************************
    // Response output
    // ************************************************
    // An upload byte not yet offered stalls the answer rather than sending a gap
    assign load = state == ST_SEND && k <= last_k && (!rsp_valid || rsp_ready) &&
        !(need_up && !up_valid);
    assign up_ready = load && need_up;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            k <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (p_done) begin
                        state <= ST_SEND;
                        k <= '0;
                    end
                end
                ST_SEND: begin
                    if (load) begin
                        k <= k + KW'(1);
                    end
                    if (rsp_valid && rsp_ready && rsp_last) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_byte <= 8'h00;
            rsp_last <= 1'b0;
            k_out <= '0;
        end else if (load) begin
            rsp_valid <= 1'b1;
            rsp_byte <= next_byte;
            rsp_last <= k == last_k;
            k_out <= k;
        end else if (rsp_ready) begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    a_err_sw_first: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && err && k_out == '0 |-> rsp_byte == sw[15:8] && !rsp_last)
        else $error("error answer does not open with SW1");
    a_err_two_bytes: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && err && rsp_last |-> k_out == KW'(1) && rsp_byte == sw[7:0])
        else $error("error answer longer than status bytes");
    a_proto_unit_zero: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !err && k_out == '0 |-> rsp_byte == 8'h00)
        else $error("protocol unit number not zero");
    a_end_pdu_zero: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !err && kind == card_cmd_pkg::CMD_SESSION_END && k_out == KW'(6)
        |-> rsp_byte == 8'h00) else $error("session end PDU number not zero");
    a_end_sw_place: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && rsp_last && !err && kind == card_cmd_pkg::CMD_SESSION_END
        |-> k_out == KW'(upload_len) + KW'(9)) else $error("session end SW2 misplaced");
    a_pon_echo_index: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !err && kind == card_cmd_pkg::CMD_POWER_ON && k_out == KW'(6)
        |-> rsp_byte == idx ##0 (rsp_valid && !rsp_ready)[*1] |=> rsp_byte == idx)
        else $error("power-on index not echoed");
    a_pon_final_index: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !err && kind == card_cmd_pkg::CMD_POWER_ON && k_out == KW'(7)
        |-> rsp_byte == info_count - 8'h01) else $error("final index not n-1");
    a_pon_sw_place: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && rsp_last && !err && kind == card_cmd_pkg::CMD_POWER_ON
        |-> k_out == KW'(19) && rsp_byte == 8'h00) else $error("power-on SW2 misplaced");
    a_bal_msb_first: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !err && kind == card_cmd_pkg::CMD_BALANCE &&
        k_out == KW'(str_len) + KW'(6) |-> rsp_byte == balance[15:8])
        else $error("balance not sent high byte first");
    a_bal_sw_place: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && rsp_last && !err && kind == card_cmd_pkg::CMD_BALANCE
        |-> k_out == KW'(str_len) + KW'(9)) else $error("balance SW2 misplaced");
    a_rsp_holds: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last))
        else $error("response byte dropped under back-pressure");
endmodule

// file: card_host_model.sv
// Host side model: sends command frames byte by byte and gathers the card's answer.
// Assumes the card's byte streams and a clock from the bench; stall comes from the bench.
`timescale 1ns/1ps
module card_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic cmd_last,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    output logic rsp_ready,
    input wire logic stall
);
    logic [8:0] got[$];
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'hA5;
        cmd_last = 1'b0;
        rsp_ready = 1'b0;
    end
    // Slow or prompt taker, changed only between edges
    always @(negedge clk) begin
        rsp_ready <= ~stall;
    end
    always @(posedge clk) begin
        if (rsp_valid && rsp_ready) begin
            got.push_back({rsp_last, rsp_byte});
        end
    end
    // Each byte held until the card is ready at a rising edge
    task automatic send(input logic [7:0] fr[$]);
        for (int i = 0; i < fr.size(); i++) begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_byte = fr[i];
            cmd_last = (i == fr.size() - 1);
            #1;
            while (!cmd_ready) begin
                @(negedge clk);
                #1;
            end
            @(posedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_last = 1'b0;
        // Released line shows the inverse, never a stale copy
        cmd_byte = ~cmd_byte;
    endtask
endmodule

// file: card_power_prepaid_commands_tb_top.sv
// Bench for the card command interpreter: host model, card data loading, byte compares.
// Assumes card_cmd_interp and card_host_model are compiled first.
`timescale 1ns/1ps
module card_power_prepaid_commands_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready, up_ready, took;
    logic stall = 1'b0;
    logic [7:0] cmd_byte, rsp_byte;
    logic [15:0] ci = 16'h0001, rc = 16'h0000, bal = 16'h0000;
    logic prepaid = 1'b1, up_valid = 1'b0, info_wr_en = 1'b0, str_wr_en = 1'b0;
    logic [7:0] final_pdu = 8'h00, upload_len = 8'h00, up_byte = 8'h00, info_count = 8'h05;
    logic [7:0] str_wr_byte = 8'h00;
    logic [3:0] info_wr_idx = 4'h0;
    logic [79:0] info_wr_rec = 80'h0;
    logic [4:0] str_wr_addr = 5'h00, str_len = 5'h01;
    logic [79:0] recs[16];
    logic [7:0] strs[21], upq[$], fr[$];
    logic [8:0] exp[$];
    logic [31:0] seed = 32'h422495F6, r;
    int bad_count = 0, check_count = 0, cycles = 0, up_i = 0;
    always #50 clk = ~clk;
    card_cmd_interp #(.INFO_DEPTH(16), .IDX_W(4)) dut_u (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_last(cmd_last),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
        .rsp_ready(rsp_ready), .card_instruction(ci), .return_code(rc), .prepaid_card(prepaid),
        .final_pdu(final_pdu), .upload_len(upload_len), .up_valid(up_valid), .up_byte(up_byte),
        .up_ready(up_ready), .info_wr_en(info_wr_en), .info_wr_idx(info_wr_idx),
        .info_wr_rec(info_wr_rec), .info_count(info_count), .str_wr_en(str_wr_en),
        .str_wr_addr(str_wr_addr), .str_wr_byte(str_wr_byte), .str_len(str_len), .balance(bal));
    card_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready), .stall(stall));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction
    // ****************************************
    // Upload source and stalls
    // ****************************************
    always @(posedge clk) begin
        took <= up_valid && up_ready;
        if (up_valid && up_ready) up_i <= up_i + 1;
    end
    // Offered byte stands until taken; idle line toggles
    always @(negedge clk) begin
        r = rnd();
        stall <= r[0];
        if (!up_valid || took) begin
            up_valid <= (up_i < upq.size()) && r[1];
            up_byte <= (up_i < upq.size() && r[1]) ? upq[up_i] : ~up_byte;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("MISMATCH %0t timeout %h %h", $time, cycles, 20000);
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Reference model and compare
    // ****************************************
    task automatic model();
        logic [15:0] sw;
        logic [7:0] d[$], b[$];
        int ln;
        exp.delete();
        ln = (fr[1] == 8'h76) ? 8 : (fr[1] == 8'h80) ? 7 : 5;
        sw = 16'h9000;
        if (fr[0][7:4] != 4'h9) sw = 16'h6E00;
        else if (fr[0][3:0] != 4'h0) sw = 16'h6800;
        else if (!(fr[1] inside {8'h76, 8'h80, 8'h44})) sw = 16'h6D00;
        else if (fr[2] != 8'h00 || fr[3] != 8'h00) sw = 16'h6A86;
        else if (fr[fr.size() - 1] != 8'h00 || fr.size() != ln) sw = 16'h6700;
        else if (fr[1] != 8'h44 && fr[4] != ((fr[1] == 8'h76) ? 8'h02 : 8'h01)) sw = 16'h6700;
        else if (fr[1] == 8'h80 && fr[5] >= info_count) sw = 16'h6A86;
        else if (fr[1] == 8'h44 && !prepaid) sw = 16'h6D00;
        if (fr[1] == 8'h76) d = {8'h00, final_pdu, upq};
        if (fr[1] == 8'h80) begin
            d = {fr[5], info_count - 8'h01};
            for (int k = 0; k < 10; k++) d.push_back(recs[fr[5][3:0]][79 - 8 * k -: 8]);
        end
        if (fr[1] == 8'h44) begin
            for (int k = 0; k < str_len; k++) d.push_back(strs[k]);
            d.push_back(bal[15:8]);
            d.push_back(bal[7:0]);
        end
        if (sw == 16'h9000) b = {8'h00, 8'(4 + d.size()), ci[15:8], ci[7:0], rc[15:8], rc[7:0], d};
        b.push_back(sw[15:8]);
        b.push_back(sw[7:0]);
        foreach (b[i]) exp.push_back({i == b.size() - 1, b[i]});
    endtask
    task automatic cmp_rsp();
        check_count++;
        if (host_u.got.size() != exp.size()) begin
            bad_count++;
            $display("MISMATCH %0t length %h %h", $time, host_u.got.size(), exp.size());
        end else begin
            foreach (exp[i]) begin
                check_count++;
                if (host_u.got[i] !== exp[i]) begin
                    bad_count++;
                    $display("MISMATCH %0t byte %h %h", $time, host_u.got[i], exp[i]);
                end
            end
        end
    endtask
    task automatic run(input string name);
        int n;
        model();
        host_u.got.delete();
        up_i = 0;
        host_u.send(fr);
        while ((host_u.got.size() == 0 || host_u.got[$][8] !== 1'b1) && n < 2000) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
        $display("test %s done", name);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 21; i++) begin
            @(negedge clk);
            if (i < 16) recs[i] = 80'({rnd(), rnd(), rnd()});
            strs[i] = 8'(rnd());
            info_wr_en = (i < 16);
            info_wr_idx = 4'(i);
            info_wr_rec = recs[i % 16];
            str_wr_en = 1'b1;
            str_wr_addr = 5'(i);
            str_wr_byte = strs[i];
        end
        @(negedge clk);
        info_wr_en = 1'b0;
        str_wr_en = 1'b0;
        rc = 16'(rnd());
        // Group and center bytes as the link application gives them
        for (int n = 0; n < 6; n += 5) begin
            upq.delete();
            repeat (n) upq.push_back(8'(rnd()));
            upload_len = 8'(n);
            final_pdu = 8'(rnd());
            fr = {8'h90, 8'h76, 8'h00, 8'h00, 8'h02, 8'h3C, 8'h5A, 8'h00};
            run("session_end");
            cmp_rsp();
        end
        upq.delete();
        ci = 16'h0001 | 16'(rnd());
        for (int i = 0; i <= 5; i++) begin
            fr = {8'h90, 8'h80, 8'h00, 8'h00, 8'h01, 8'(i), 8'h00};
            run("power_on");
            cmp_rsp();
        end
        for (int i = 0; i < 3; i++) begin
            prepaid = (i < 2);
            str_len = (i == 0) ? 5'h01 : 5'h15;
            bal = 16'(rnd());
            fr = {8'h90, 8'h44, 8'h00, 8'h00, 8'h00};
            run("balance");
            cmp_rsp();
        end
        prepaid = 1'b1;
        for (int i = 0; i < 6; i++) begin
            fr = {8'h90, 8'h44, 8'h00, 8'h00, 8'h00};
            case (i)
                0: fr[0] = 8'h80;
                1: fr[0] = 8'h91;
                2: fr[1] = 8'h33;
                3: fr[2] = 8'h01;
                4: fr[4] = 8'h01;
                default: fr.pop_back();
            endcase
            run("error");
            cmp_rsp();
        end
        final_report();
    end
endmodule
